// ### core/wake_seq_regs.svh
`ifndef WAKE_SEQ_REGS_SVH
`define WAKE_SEQ_REGS_SVH
// boot and user code addresses
`define BOOT_ROM_ADDR 12'h800
`define USER_EPR_ADDR 12'h030
// status register 22 bit positions
`define STAT_WDT_BIT 17
`define STAT_BUTTON_BIT 18
`define STAT_SLEEP_WAKE_BIT 22
// configuration bit positions
`define CFG_SLEEP_BIT 17
`define CFG_CONV_MSB 23
`define CFG_CONV_LSB 14
// timing
`define OSC_HZ 10000
`define CLK_HZ 100000000
`define CONV_PRESCALE 64
`define RTC_PERIOD_MS 10
`define RTC_TICKS ((`OSC_HZ * `RTC_PERIOD_MS) / 1000)
`define WDT_LIMIT 3'h4
`define RTC_RAM_ADDR 6'h1d
`endif

// ### core/wake_seq_pkg.sv
package wake_seq_pkg;
  typedef enum logic [2:0] {
    st_stopped = 3'b000,
    st_boot = 3'b001,
    st_config = 3'b011,
    st_user = 3'b010,
    st_halt = 3'b110
  } state_type;

  typedef struct packed {
    logic cfg_copy;
    logic pwr_prg;
    logic usr_prg;
  } flags_type;

  typedef struct packed {
    logic wdt_timeout;
    logic button;
    logic sleep_wake;
    logic reset_wake;
  } status_type;
endpackage : wake_seq_pkg

// ### core/wake_reset_sleep_sequencer.sv
`timescale 1ns/1ns
`include "wake_seq_regs.svh"
// Behaviour
// - wake on reset, measurement end, counter end
// - every wake starts at boot ROM
// - reset wake copies config when flagged
// - reset wake jumps user code or stops
// - other wake measures or restarts, maybe jumps
// - stop clears start flags and stack
// - power-on resets everything except RAM
// - four unwatched starts force reset, flag
// - stand-alone pin acts as reset button
// - sleep wakes flagged without measurement
// - sleep bit equals averaging rate zero
// - sleep counter end starts user code
// - conversion rate is tick/64/count
// - watchdog counts measurement starts
// - watchdog off command, pin edges clear
// - 24-bit 10 ms timer, clearable
// - oscillator tick is the base timebase
module wake_reset_sleep_sequencer
  import wake_seq_pkg::*;
#(
  parameter int CONV_W = 10,
  parameter int OSC_DIV = `CLK_HZ / `OSC_HZ
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // configuration
  input wire logic [23:0] cfg_reg0,
  input wire logic [23:0] cfg_reg1,
  input wire flags_type flags,
  input wire logic serial_port_enable,
  input wire logic wdt_off_cmd,
  // pin
  input wire logic select_or_reset_pin,
  // processor and measurement side
  input wire logic measure_done,
  input wire logic cpu_stop,
  input wire logic wdt_clear_instr,
  input wire logic rtc_clear_instr,
  input wire logic config_copy_done,
  output logic osc_tick,
  output logic measure_start,
  output logic config_copy_req,
  output logic cpu_run,
  output logic [11:0] cpu_pc,
  output logic cpu_flags_clear,
  output logic chip_reset,
  output logic sleep_mode,
  output status_type status,
  output logic [23:0] rtc_value
);

  //------------------------------------------------------------
  // base tick from the oscillator
  //------------------------------------------------------------
  localparam int OSC_W = $clog2(OSC_DIV);
  logic [OSC_W-1:0] osc_cnt_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      osc_cnt_r <= '0;
      osc_tick <= 1'b0;
    end else begin
      osc_tick <= 1'b0;
      if (osc_cnt_r == OSC_W'(OSC_DIV - 1)) begin
        osc_cnt_r <= '0;
        osc_tick <= 1'b1;
      end else begin
        osc_cnt_r <= osc_cnt_r + 1'b1;
      end
    end
  end

  //------------------------------------------------------------
  // pin synchroniser and button reset
  //------------------------------------------------------------
  logic [2:0] pin_sync_r;
  logic pin_level_r;
  logic pin_edge;
  logic button_reset;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pin_sync_r <= 3'h7;
      pin_level_r <= 1'b1;
    end else begin
      pin_sync_r <= {pin_sync_r[1:0], select_or_reset_pin};
      if (pin_sync_r[1] == pin_sync_r[2]) begin
        pin_level_r <= pin_sync_r[2];
      end
    end
  end
  assign pin_edge = (pin_sync_r[1] == pin_sync_r[2]) && (pin_sync_r[2] != pin_level_r);
  // a low pin in stand-alone mode holds the chip in chip_reset with a reset wake pending
  assign button_reset = !serial_port_enable && !pin_level_r;

  assign sleep_mode = cfg_reg1[`CFG_SLEEP_BIT];

  //------------------------------------------------------------
  // conversion counter
  //------------------------------------------------------------
  logic [5:0] pre_r;
  logic [CONV_W-1:0] conv_r;
  logic conv_end;
  logic restart_conv;
  logic [CONV_W-1:0] conv_load;
  assign conv_load = CONV_W'(cfg_reg0[`CFG_CONV_MSB:`CFG_CONV_LSB]);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pre_r <= '0;
      conv_r <= '0;
      conv_end <= 1'b0;
    end else begin
      conv_end <= 1'b0;
      if (restart_conv) begin
        pre_r <= '0;
        conv_r <= '0;
      end else if (osc_tick) begin
        pre_r <= pre_r + 1'b1;
        if (pre_r == 6'(`CONV_PRESCALE - 1)) begin
          if (conv_r + 1'b1 >= conv_load) begin
            conv_r <= '0;
            conv_end <= 1'b1;
          end else begin
            conv_r <= conv_r + 1'b1;
          end
        end
      end
    end
  end

  //------------------------------------------------------------
  // wake arbitration and pending requests
  //------------------------------------------------------------
  logic reset_pend_r;
  logic meas_pend_r;
  logic sleep_pend_r;
  logic wdt_fire;
  state_type state_r;
  logic is_reset_wake_r;
  logic wake_take;
  assign wake_take = (state_r == st_stopped) && (reset_pend_r || meas_pend_r || sleep_pend_r);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reset_pend_r <= 1'b1;
      meas_pend_r <= 1'b0;
      sleep_pend_r <= 1'b0;
    end else begin
      // sets win over the take so nothing arriving now is lost
      if (wake_take) begin
        reset_pend_r <= 1'b0;
        if (!reset_pend_r) begin
          meas_pend_r <= 1'b0;
          sleep_pend_r <= 1'b0;
        end
      end
      if (wdt_fire || button_reset) reset_pend_r <= 1'b1;
      if (measure_done) meas_pend_r <= 1'b1;
      if (conv_end && sleep_mode) sleep_pend_r <= 1'b1;
    end
  end

  //------------------------------------------------------------
  // processor sequence
  //------------------------------------------------------------
  assign cpu_run = (state_r != st_stopped) && (state_r != st_halt);
  assign config_copy_req = (state_r == st_config);
  assign chip_reset = wdt_fire || button_reset;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r <= st_stopped;
      cpu_pc <= 12'h000;
      is_reset_wake_r <= 1'b0;
      cpu_flags_clear <= 1'b0;
    end else begin
      cpu_flags_clear <= 1'b0;
      case (state_r)
        st_stopped: begin
          if (wake_take) begin
            state_r <= st_boot;
            cpu_pc <= `BOOT_ROM_ADDR;
            is_reset_wake_r <= reset_pend_r;
          end
        end
        st_boot: begin
          if (is_reset_wake_r) begin
            if (flags.cfg_copy) begin
              state_r <= st_config;
            end else if (flags.pwr_prg) begin
              state_r <= st_user;
              cpu_pc <= `USER_EPR_ADDR;
            end else begin
              state_r <= st_halt;
            end
          end else if (flags.usr_prg) begin
            state_r <= st_user;
            cpu_pc <= `USER_EPR_ADDR;
          end else begin
            state_r <= st_halt;
          end
        end
        st_config: begin
          if (config_copy_done) begin
            if (flags.pwr_prg) begin
              state_r <= st_user;
              cpu_pc <= `USER_EPR_ADDR;
            end else begin
              state_r <= st_halt;
            end
          end
        end
        st_user: begin
          if (cpu_stop) state_r <= st_halt;
        end
        st_halt: begin
          state_r <= st_stopped;
          cpu_pc <= 12'h000;
          cpu_flags_clear <= 1'b1;
        end
        default: state_r <= st_stopped;
      endcase
      if (chip_reset) begin
        state_r <= st_stopped;
        cpu_pc <= 12'h000;
        cpu_flags_clear <= 1'b1;
      end
    end
  end

  // non-reset wake: measure, or in sleep restart the counter only
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      measure_start <= 1'b0;
    end else begin
      measure_start <= (wake_take && !reset_pend_r && !sleep_mode)
        || (conv_end && !sleep_mode);
    end
  end
  assign restart_conv = wake_take && !reset_pend_r && sleep_mode;

  //------------------------------------------------------------
  // watchdog
  //------------------------------------------------------------
  logic [2:0] wdt_r;
  logic wdt_dis_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdt_dis_r <= 1'b0;
    end else if (serial_port_enable && wdt_off_cmd) begin
      wdt_dis_r <= 1'b1;
    end
  end
  assign wdt_fire = !wdt_dis_r && (wdt_r == `WDT_LIMIT);
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wdt_r <= 3'h0;
    end else if (wdt_clear_instr || pin_edge || wdt_fire) begin
      wdt_r <= 3'h0;
    end else if (measure_start || restart_conv) begin
      wdt_r <= wdt_r + 3'h1;
    end
  end

  //------------------------------------------------------------
  // status bits
  //------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      status <= '0;
    end else begin
      status.button <= !pin_level_r && !serial_port_enable;
      if (wdt_fire) status.wdt_timeout <= 1'b1;
      else if (button_reset) status.wdt_timeout <= 1'b0;
      if (wake_take) begin
        status.sleep_wake <= !reset_pend_r && sleep_pend_r && !meas_pend_r;
        status.reset_wake <= reset_pend_r;
      end
    end
  end

  //------------------------------------------------------------
  // real-time counter, reset only by power-on
  //------------------------------------------------------------
  localparam int RTC_W = $clog2(`RTC_TICKS);
  logic [RTC_W-1:0] rtc_pre_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rtc_pre_r <= '0;
      rtc_value <= 24'h000000;
    end else if (rtc_clear_instr) begin
      rtc_pre_r <= '0;
      rtc_value <= 24'h000000;
    end else if (osc_tick) begin
      if (rtc_pre_r == RTC_W'(`RTC_TICKS - 1)) begin
        rtc_pre_r <= '0;
        rtc_value <= rtc_value + 24'h000001;
      end else begin
        rtc_pre_r <= rtc_pre_r + 1'b1;
      end
    end
  end

endmodule : wake_reset_sleep_sequencer

// ### tb/wake_seq_assertions.sv
`timescale 1ns/1ns
module wake_seq_checker
  import wake_seq_pkg::*;
#(
  parameter int CONV_W = 10,
  parameter int OSC_DIV = 10000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input wire logic [23:0] cfg_reg1,
  input wire logic serial_port_enable,
  input wire logic cpu_stop,
  input wire logic rtc_clear_instr,
  input wire logic osc_tick,
  input wire logic measure_start,
  input wire logic cpu_run,
  input wire logic [11:0] cpu_pc,
  input wire logic cpu_flags_clear,
  input wire logic chip_reset,
  input wire logic sleep_mode,
  input wire status_type status,
  input wire logic [23:0] rtc_value
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // gap counter: the first tick after reset has no reference, so it is skipped
  int gap_r;
  logic seen_r;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) gap_r <= 0;
    else gap_r <= osc_tick ? 0 : gap_r + 1;
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst) seen_r <= 1'b0;
    else if (osc_tick) seen_r <= 1'b1;
  end
  a_reset_wake_boot: assert property ($fell(rst) |-> ##[0:2] cpu_pc == 12'h800)
    else $error("no boot fetch after reset");
  a_stop_clears_flags: assert property (cpu_run && cpu_stop |-> ##[1:3] cpu_flags_clear)
    else $error("stop without flag clear");
  a_sleep_bit_follows: assert property (sleep_mode == cfg_reg1[17])
    else $error("sleep mode differs from config bit");
  a_tick_period: assert property (osc_tick && seen_r |-> gap_r == OSC_DIV - 1)
    else $error("oscillator tick spacing wrong");
  a_wdt_sets_flag: assert property (chip_reset && serial_port_enable
    |-> ##[1:2] status.wdt_timeout)
    else $error("watchdog reset without status flag");
  a_sleep_no_measure: assert property (measure_start |-> !$past(sleep_mode))
    else $error("measurement started in sleep mode");
  a_rtc_clear_zero: assert property (rtc_clear_instr |=> rtc_value == 24'h000000)
    else $error("timer not cleared");
  a_rtc_single_step: assert property (rtc_value != $past(rtc_value)
    && !$past(rtc_clear_instr) && !$past(chip_reset)
    |-> rtc_value == $past(rtc_value) + 24'h000001)
    else $error("timer step not one");
  c_measure: cover property (measure_start);
  c_chip_reset: cover property (chip_reset);
  c_sleep_wake: cover property (status.sleep_wake);
  c_user_jump: cover property (cpu_pc == 12'h030);
endmodule : wake_seq_checker

bind wake_reset_sleep_sequencer wake_seq_checker #(.CONV_W(CONV_W), .OSC_DIV(OSC_DIV)) chk (
  .clock(clock), .rst(rst), .cfg_reg1(cfg_reg1), .serial_port_enable(serial_port_enable),
  .cpu_stop(cpu_stop), .rtc_clear_instr(rtc_clear_instr), .osc_tick(osc_tick),
  .measure_start(measure_start), .cpu_run(cpu_run), .cpu_pc(cpu_pc),
  .cpu_flags_clear(cpu_flags_clear), .chip_reset(chip_reset), .sleep_mode(sleep_mode),
  .status(status), .rtc_value(rtc_value)
);

// ### tb/tb_top.sv
`timescale 1ns/1ns
module tb_top;
  import wake_seq_pkg::*;
  logic clock, rst, spe, pin, mdone, stop, wclr, tclr, cdone, woff;
  logic [23:0] cfg0, cfg1, rtc;
  flags_type flags;
  logic tick, mstart, creq, run, fclr, creset, sleep;
  logic [11:0] pc;
  status_type status;
  int failures, cmp_count, cycles, nuser;
  logic saw_cfg, saw_meas, saw_rst, saw_sleep;
  typedef struct packed {logic by_reset; flags_type f; logic cfg, user, meas;} row_type;
  row_type rows [6] = '{7'b1_100_100, 7'b1_010_010, 7'b1_111_110, 7'b1_001_000,
    7'b0_000_001, 7'b0_101_011};
  wake_reset_sleep_sequencer #(.OSC_DIV(4)) dut (.clock(clock), .rst(rst), .cfg_reg0(cfg0),
    .cfg_reg1(cfg1), .flags(flags), .serial_port_enable(spe), .wdt_off_cmd(woff),
    .select_or_reset_pin(pin), .measure_done(mdone), .cpu_stop(stop),
    .wdt_clear_instr(wclr), .rtc_clear_instr(tclr), .config_copy_done(cdone),
    .osc_tick(tick), .measure_start(mstart), .config_copy_req(creq), .cpu_run(run),
    .cpu_pc(pc), .cpu_flags_clear(fclr), .chip_reset(creset), .sleep_mode(sleep),
    .status(status), .rtc_value(rtc));
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task finish_test;
    $display("failures %0d comparisons %0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      failures++;
      finish_test();
    end
  end
  task check(input string name, input logic [23:0] exp, input logic [23:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask : check
  // plays the processor: answers copy requests, stops user code at once
  task watch(input int n);
    saw_cfg = 1'b0; saw_meas = 1'b0; saw_rst = 1'b0; saw_sleep = 1'b0; nuser = 0;
    repeat (n) begin
      @(negedge clock);
      mdone = 0; stop = 0; cdone = creq;
      if (run && pc == 12'h030) begin
        stop = 1;
        nuser++;
      end
      saw_cfg |= creq; saw_meas |= mstart; saw_rst |= creset; saw_sleep |= status.sleep_wake;
    end
  endtask : watch
  task automatic pulse(ref logic s);
    @(negedge clock) s = 1;
    @(negedge clock) s = 0;
  endtask : pulse
  task wake_meas;
    @(negedge clock) mdone = 1;
    watch(20);
  endtask : wake_meas
  initial begin
    rst = 1; spe = 1; pin = 1; mdone = 0; stop = 0; wclr = 0; tclr = 0; cdone = 0; woff = 0;
    cfg0 = 24'hffc000; cfg1 = 24'h0; flags = 3'h0;
    repeat (3) @(posedge clock);
    @(negedge clock) rst = 0;
    watch(20);
    // --------------------------------------------------------
    // table of wake kinds and boot flags
    // --------------------------------------------------------
    foreach (rows[i]) begin
      @(negedge clock) flags = rows[i].f;
      if (rows[i].by_reset) begin
        rst = 1;
        @(negedge clock) rst = 0;
        watch(20);
      end else wake_meas();
      check("config_copy_req", 24'(rows[i].cfg), 24'(saw_cfg));
      check("user jumps", 24'(rows[i].user), nuser[23:0]);
      check("measure_start", 24'(rows[i].meas), 24'(saw_meas));
      check("status reset_wake", 24'(rows[i].by_reset), 24'(status.reset_wake));
      check("cpu_run after stop", 24'h0, 24'(run));
    end
    // --------------------------------------------------------
    // watchdog, pending wakes, sleep, button, timer
    // --------------------------------------------------------
    flags = 3'h0;
    pulse(wclr);
    repeat (3) wake_meas();
    pulse(wclr);
    repeat (3) wake_meas();
    check("chip_reset after clear", 24'h0, 24'(saw_rst));
    wake_meas();
    check("chip_reset on fourth start", 24'h1, 24'(saw_rst));
    check("wdt_timeout", 24'h1, 24'(status.wdt_timeout));
    pulse(wclr);
    flags = 3'h1;
    @(negedge clock) mdone = 1;
    @(negedge clock) mdone = 1;
    watch(40);
    check("user runs for two wakes", 24'h2, nuser[23:0]);
    pulse(wclr);
    cfg0 = 24'h004000;
    cfg1 = 24'h020000;
    watch(300);
    check("sleep_wake", 24'h1, 24'(saw_sleep));
    check("measure in sleep", 24'h0, 24'(saw_meas));
    check("user run from sleep", 24'h1, 24'(nuser != 0));
    // firmware would reinitialise the measurement unit here; it has no port
    cfg1 = 24'h0;
    pulse(wclr);
    watch(300);
    check("measure_start at conversion end", 24'h1, 24'(saw_meas));
    cfg0 = 24'hffc000;
    spe = 0;
    pin = 0;
    watch(6);
    check("chip_reset while button held", 24'h1, 24'(creset));
    check("status button", 24'h1, 24'(status.button));
    pin = 1;
    watch(420);
    check("timer running", 24'h1, 24'(rtc != 0));
    pulse(tclr);
    check("timer cleared", 24'h0, rtc);
    // in serial mode the pin is no reset, but its edges clear the watchdog
    spe = 1;
    pulse(wclr);
    repeat (3) wake_meas();
    pin = 0;
    watch(6);
    check("status button in serial mode", 24'h0, 24'(status.button));
    pin = 1;
    watch(6);
    wake_meas();
    check("chip_reset after pin edges", 24'h0, 24'(saw_rst));
    pulse(woff);
    repeat (4) begin
      wake_meas();
      check("chip_reset with watchdog off", 24'h0, 24'(saw_rst));
    end
    finish_test();
  end
endmodule : tb_top
